// File: hw/periodic_timer.sv
// Function
// R1 - ten-bit up counter, one step per selected clock edge while on and unpaused
// R2 - three-bit clock select picks sys/4, sys, high/16, high/64, sub, pin edges
// R3 - pause bit holds count; clearing resumes from held value
// R4 - run bit rising resets counter; only software way to alter it
// R5 - run bit falling stops counting and keeps residual count
// R6 - run bit rising forces output to initial level in output modes
// R7 - counter clears on overflow or comparator match, raising interrupt pulse
// R8 - two comparators, compare A and ten-bit period, compared continuously
// R9 - counter read-only byte pair; compare A and period read/write byte pairs
// R10 - mode field: compare out, capture, pwm/single pulse, timer
// R11 - compare out: on A match keep, low, high or toggle output
// R12 - pwm mode: forced inactive, forced active, pwm wave or single pulse
// R13 - capture on rising, falling or both pin edges; code three disables
// R14 - capture trigger comes only from the external input pin
// R15 - requested level equal to initial level gives no visible change
// R16 - software should stop the timer before changing mode
// R17 - software changes pin function in pwm mode only while off
// R18 - timer mode: output pin not driven, pin function ignored
// R19 - low three bits of first control register read zero
// R20 - output control bit sets initial level or active level
// R21 - polarity bit inverts output, ignored in timer mode; code applies it in every mode, including the status out bit
// R22 - clear select: A match, else P match or overflow when period zero
// R23 - software sets capture source bit in capture mode
// R24 - external pin synchronised before use as count or capture event
`default_nettype none
module periodic_timer
    import periodic_timer_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic sub_clk_tick,
    input wire avl_req_t avl_req,
    output avl_rsp_t avl_rsp,
    input wire logic ext_clk_capture_pin,
    output logic wave_out_pin,
    output logic wave_out_en,
    output logic timer_irq
);
    typedef struct packed {
        ctrl_a_t ctrl_a;
        ctrl_b_t ctrl_b;
        logic [CNT_W-1:0] count;
        logic [CNT_W-1:0] compare_a_value;
        logic [CNT_W-1:0] period_compare_value;
        logic [7:0] prescale;
        logic [1:0] pin_sync;
        logic pin_prev;
        logic wave;
        logic [31:0] rdata;
        logic ack;
        logic irq;
        logic out;
        logic oen;
    } state_t;

    state_t st_ff;
    state_t nxt_st;

    function automatic logic [CNT_W-1:0] set_byte(input logic [CNT_W-1:0] v,
            input logic hi, input logic [7:0] d);
        set_byte = hi ? {d[1:0], v[7:0]} : {v[9:8], d};
    endfunction

    logic pin_s;
    logic pin_rise;
    logic pin_fall;
    logic tick;
    logic run_rise;
    logic match_a;
    logic match_p;
    logic ovf;
    logic do_clear;
    logic cap_evt;
    logic [CNT_W-1:0] cnt_inc;
    logic level;
    logic [7:0] rb;

    always_comb begin
        nxt_st = st_ff;
        pin_s = st_ff.pin_sync[1]; // R24
        pin_rise = pin_s && !st_ff.pin_prev;
        pin_fall = !pin_s && st_ff.pin_prev;
        nxt_st.pin_sync = {st_ff.pin_sync[0], ext_clk_capture_pin}; // R24
        nxt_st.pin_prev = pin_s;
        nxt_st.prescale = st_ff.prescale + 8'h01;
        tick = 1'b0;
        case (st_ff.ctrl_a.clk_select) // R2
            3'h0: tick = (st_ff.prescale[1:0] == CLK_DIV_SYS4[1:0]);
            3'h1: tick = 1'b1;
            3'h2: tick = (st_ff.prescale[3:0] == CLK_DIV_H16[3:0]);
            3'h3: tick = (st_ff.prescale[5:0] == CLK_DIV_H64);
            3'h4, 3'h5: tick = sub_clk_tick;
            3'h6: tick = pin_rise;
            default: tick = pin_fall;
        endcase
        match_a = (st_ff.count == st_ff.compare_a_value); // R8
        match_p = (st_ff.count == st_ff.period_compare_value); // R8
        ovf = (st_ff.count == {CNT_W{1'b1}});
        cnt_inc = st_ff.count + 10'h001; // R1
        do_clear = 1'b0;
        run_rise = 1'b0;
        nxt_st.irq = 1'b0;
        level = st_ff.ctrl_b.out_init_level;
        cap_evt = 1'b0;
        // capture input from the pin only
        if (st_ff.ctrl_b.op_mode_sel == MODE_CAPTURE) begin // R14
            case (st_ff.ctrl_b.pin_func_sel) // R13
                2'h0: cap_evt = pin_rise;
                2'h1: cap_evt = pin_fall;
                2'h2: cap_evt = pin_rise || pin_fall;
                default: cap_evt = 1'b0;
            endcase
        end
        if (st_ff.ctrl_a.run_ctrl && cap_evt) begin
            nxt_st.compare_a_value = st_ff.count;
            nxt_st.irq = 1'b1;
        end
        // counting and clear
        if (st_ff.ctrl_a.run_ctrl && !st_ff.ctrl_a.pause_ctrl && tick) begin // R1 R3 R5
            if (st_ff.ctrl_b.op_mode_sel == MODE_CMP_OUT
                    || st_ff.ctrl_b.op_mode_sel == MODE_TIMER) begin
                if (st_ff.ctrl_b.clear_src_sel) begin // R22
                    do_clear = match_a;
                end else if (st_ff.period_compare_value == CMP_RST) begin
                    do_clear = ovf;
                end else begin
                    do_clear = match_p;
                end
            end else if (st_ff.ctrl_b.op_mode_sel == MODE_CAPTURE) begin
                do_clear = (st_ff.period_compare_value == CMP_RST) ? ovf : match_p;
            end else if (st_ff.ctrl_b.pin_func_sel != 2'h3) begin
                do_clear = (st_ff.period_compare_value == CMP_RST) ? ovf : match_p;
            end
            nxt_st.count = do_clear ? CMP_RST : cnt_inc; // R7
            if (do_clear) begin
                nxt_st.irq = 1'b1; // R7
            end
            if (st_ff.ctrl_b.op_mode_sel == MODE_CMP_OUT && match_a) begin // R11 R15
                case (st_ff.ctrl_b.pin_func_sel)
                    2'h1: nxt_st.wave = 1'b0;
                    2'h2: nxt_st.wave = 1'b1;
                    2'h3: nxt_st.wave = !st_ff.wave;
                    default: nxt_st.wave = st_ff.wave;
                endcase
                nxt_st.irq = 1'b1;
            end
            if (st_ff.ctrl_b.op_mode_sel == MODE_PWM && st_ff.ctrl_b.pin_func_sel == 2'h3
                    && match_a) begin
                nxt_st.ctrl_a.run_ctrl = 1'b0;
                nxt_st.irq = 1'b1;
            end
        end
        // bus slave, one wait state per access
        nxt_st.ack = 1'b0;
        if ((avl_req.read || avl_req.write) && !st_ff.ack) begin
            nxt_st.ack = 1'b1;
            if (avl_req.write) begin
                if (avl_req.address == IDX_CTRL_A) begin
                    nxt_st.ctrl_a = ctrl_a_t'(avl_req.writedata[7:0] & CTRL_A_MASK); // R19
                    run_rise = avl_req.writedata[3] && !st_ff.ctrl_a.run_ctrl;
                end else if (avl_req.address == IDX_CTRL_B) begin
                    nxt_st.ctrl_b = ctrl_b_t'(avl_req.writedata[7:0]); // R10 R16 R17
                end else if (avl_req.address == IDX_CMPA_LO
                        || avl_req.address == IDX_CMPA_HI) begin
                    nxt_st.compare_a_value = set_byte(st_ff.compare_a_value,
                        avl_req.address[0], avl_req.writedata[7:0]); // R9
                end else if (avl_req.address == IDX_PER_LO
                        || avl_req.address == IDX_PER_HI) begin
                    nxt_st.period_compare_value = set_byte(st_ff.period_compare_value,
                        avl_req.address[0], avl_req.writedata[7:0]); // R9
                end
            end
        end
        if (run_rise) begin
            nxt_st.count = CMP_RST; // R4
            nxt_st.wave = st_ff.ctrl_b.out_init_level; // R6
        end
        // readback
        rb = 8'h00;
        if (avl_req.address == IDX_CTRL_A) begin
            rb = st_ff.ctrl_a & CTRL_A_MASK; // R19
        end else if (avl_req.address == IDX_CTRL_B) begin
            rb = st_ff.ctrl_b;
        end else if (avl_req.address == IDX_COUNT_LO) begin
            rb = st_ff.count[7:0]; // R9
        end else if (avl_req.address == IDX_COUNT_HI) begin
            rb = {6'h00, st_ff.count[9:8]};
        end else if (avl_req.address == IDX_CMPA_LO) begin
            rb = st_ff.compare_a_value[7:0];
        end else if (avl_req.address == IDX_CMPA_HI) begin
            rb = {6'h00, st_ff.compare_a_value[9:8]};
        end else if (avl_req.address == IDX_PER_LO) begin
            rb = st_ff.period_compare_value[7:0];
        end else if (avl_req.address == IDX_PER_HI) begin
            rb = {6'h00, st_ff.period_compare_value[9:8]};
        end else if (avl_req.address == IDX_STATUS) begin
            rb = {6'h00, st_ff.out, st_ff.ctrl_a.run_ctrl};
        end
        nxt_st.rdata = {24'h000000, rb};
        // output pin
        case (st_ff.ctrl_b.op_mode_sel)
            MODE_CMP_OUT: level = st_ff.wave; // R20
            MODE_PWM: begin
                case (st_ff.ctrl_b.pin_func_sel) // R12
                    2'h0: level = !st_ff.ctrl_b.out_init_level;
                    2'h1: level = st_ff.ctrl_b.out_init_level;
                    2'h2: level = st_ff.ctrl_a.run_ctrl
                        && (st_ff.count < st_ff.compare_a_value)
                        ? st_ff.ctrl_b.out_init_level : !st_ff.ctrl_b.out_init_level;
                    default: level = st_ff.ctrl_a.run_ctrl
                        ? st_ff.ctrl_b.out_init_level : !st_ff.ctrl_b.out_init_level;
                endcase
            end
            default: level = st_ff.ctrl_b.out_init_level;
        endcase
        nxt_st.out = level ^ st_ff.ctrl_b.out_invert; // R21
        nxt_st.oen = (st_ff.ctrl_b.op_mode_sel == MODE_CMP_OUT)
            || (st_ff.ctrl_b.op_mode_sel == MODE_PWM); // R18
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= '0;
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end

    assign avl_rsp.readdata = st_ff.rdata;
    assign avl_rsp.waitrequest = !st_ff.ack;
    assign wave_out_pin = st_ff.out;
    assign wave_out_en = st_ff.oen;
    assign timer_irq = st_ff.irq;
endmodule
`default_nettype wire

// File: inc/periodic_timer_pkg.sv
`default_nettype none
package periodic_timer_pkg;
    // register indices; byte address is four times the index
    localparam logic [3:0] IDX_CTRL_A = 4'h0;
    localparam logic [3:0] IDX_CTRL_B = 4'h1;
    localparam logic [3:0] IDX_COUNT_LO = 4'h2;
    localparam logic [3:0] IDX_COUNT_HI = 4'h3;
    localparam logic [3:0] IDX_CMPA_LO = 4'h4;
    localparam logic [3:0] IDX_CMPA_HI = 4'h5;
    localparam logic [3:0] IDX_PER_LO = 4'h6;
    localparam logic [3:0] IDX_PER_HI = 4'h7;
    localparam logic [3:0] IDX_STATUS = 4'h8;
    localparam int CNT_W = 10;
    localparam logic [7:0] CTRL_A_RST = 8'h00;
    localparam logic [7:0] CTRL_B_RST = 8'h00;
    localparam logic [7:0] CTRL_A_MASK = 8'hF8;
    localparam logic [9:0] CMP_RST = 10'h000;
    localparam logic [2:0] CLK_DIV_SYS4 = 3'h3;
    localparam logic [5:0] CLK_DIV_H16 = 6'h0F;
    localparam logic [5:0] CLK_DIV_H64 = 6'h3F;
    localparam logic [7:0] CLK_DIV_SUB = 8'hFF;

    typedef enum logic [1:0] {
        MODE_CMP_OUT,
        MODE_CAPTURE,
        MODE_PWM,
        MODE_TIMER
    } op_mode_t;

    typedef struct packed {
        logic pause_ctrl;
        logic [2:0] clk_select;
        logic run_ctrl;
        logic [2:0] unused;
    } ctrl_a_t;

    typedef struct packed {
        op_mode_t op_mode_sel;
        logic [1:0] pin_func_sel;
        logic out_init_level;
        logic out_invert;
        logic capture_src_sel;
        logic clear_src_sel;
    } ctrl_b_t;

    typedef struct packed {
        logic [3:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } avl_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } avl_rsp_t;
endpackage
`default_nettype wire

// File: verif/pin_partner.sv
`default_nettype none
module pin_partner (
    input wire logic clk,
    output logic ext_clk_capture_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    initial ext_clk_capture_pin = 1'b0;
    // pulses held four cycles high and five low between pulses so the two-flop sync sees them
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge clk);
            ext_clk_capture_pin <= 1'b1;
            repeat (4) @(posedge clk);
            ext_clk_capture_pin <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask
endmodule
`default_nettype wire

// File: verif/periodic_timer_asserts.sv
`default_nettype none
module periodic_timer_asserts
    import periodic_timer_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic sub_clk_tick,
    input wire avl_req_t avl_req,
    input wire avl_rsp_t avl_rsp,
    input wire logic ext_clk_capture_pin,
    input wire logic wave_out_pin,
    input wire logic wave_out_en,
    input wire logic timer_irq
);
    logic ack;
    logic rd;
    logic [7:0] b_ff;
    logic [7:0] per_ff;
    logic [1:0] m;
    assign ack = !avl_rsp.waitrequest && avl_req.write;
    assign rd = !avl_rsp.waitrequest && avl_req.read;
    assign m = b_ff[7:6];
    // shadow of control b and period low writes seen on the bus
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            b_ff <= CTRL_B_RST;
            per_ff <= CMP_RST[7:0];
        end else if (ack && clk_en) begin
            if (avl_req.address == IDX_CTRL_B) b_ff <= avl_req.writedata[7:0];
            if (avl_req.address == IDX_PER_LO) per_ff <= avl_req.writedata[7:0];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    chk_ack_one_cycle: assert property (
        !avl_rsp.waitrequest && clk_en |=> avl_rsp.waitrequest)
        else $error("waitrequest low for more than one cycle");
    chk_ack_has_req: assert property (
        $fell(avl_rsp.waitrequest) |-> $past(avl_req.read) || $past(avl_req.write))
        else $error("answer without a request");
    chk_rd_upper_zero: assert property (
        rd |-> avl_rsp.readdata[31:8] == 24'h000000)
        else $error("upper read data not zero");
    chk_ctrl_a_low: assert property (
        rd && avl_req.address == IDX_CTRL_A |-> avl_rsp.readdata[2:0] == 3'h0)
        else $error("control a low bits not zero");
    chk_ctrl_b_back: assert property (
        rd && avl_req.address == IDX_CTRL_B |-> avl_rsp.readdata[7:0] == b_ff)
        else $error("control b readback wrong");
    chk_period_back: assert property (
        rd && avl_req.address == IDX_PER_LO |-> avl_rsp.readdata[7:0] == per_ff)
        else $error("period low readback wrong");
    chk_unmapped_zero: assert property (
        rd && avl_req.address > IDX_STATUS |-> avl_rsp.readdata == 32'h00000000)
        else $error("unmapped read not zero");
    chk_out_enable: assert property (
        $past(arst_n, 2) && $past(clk_en) && $stable(m) && m == $past(m, 2)
        |-> wave_out_en == (m == 2'h0 || m == 2'h2))
        else $error("output enable disagrees with mode");
    cov_write: cover property (ack);
    cov_irq: cover property (timer_irq);
    cov_wave_rise: cover property ($rose(wave_out_pin));
endmodule
bind periodic_timer periodic_timer_asserts u_chk (.clk(clk), .arst_n(arst_n),
    .clk_en(clk_en), .sub_clk_tick(sub_clk_tick), .avl_req(avl_req), .avl_rsp(avl_rsp),
    .ext_clk_capture_pin(ext_clk_capture_pin), .wave_out_pin(wave_out_pin),
    .wave_out_en(wave_out_en), .timer_irq(timer_irq));
`default_nettype wire

// File: verif/periodic_timer_tb_top.sv
`default_nettype none
module periodic_timer_tb_top
    import periodic_timer_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic sub_clk_tick = 1'b0;
    logic pin, wave, wave_en, irq;
    avl_req_t req = '0;
    avl_rsp_t rsp;
    int bad_count = 0;
    int n_compared = 0;
    int irq_seen = 0;
    int irq_base = 0;
    logic [31:0] seed = 32'h518009CF;
    logic [31:0] r;
    logic [7:0] q, q2;
    always #10 clk = ~clk;
    periodic_timer dut (.clk(clk), .arst_n(arst_n), .clk_en(1'b1), .sub_clk_tick(sub_clk_tick),
        .avl_req(req), .avl_rsp(rsp), .ext_clk_capture_pin(pin), .wave_out_pin(wave),
        .wave_out_en(wave_en), .timer_irq(irq));
    pin_partner peer (.clk(clk), .ext_clk_capture_pin(pin));
    always @(posedge clk) begin
        if (irq === 1'b1) irq_seen++;
    end
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic bit in_win(input logic [7:0] g, input int e, input bit loose);
        return loose ? (g >= e - 1 && g <= e + 4) : g == e;
    endfunction
    function automatic logic lvl(input logic [1:0] f, input logic i);
        return f == 2'h0 ? i : f == 2'h3 ? !i : f[1];
    endfunction
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{address: a, read: !w, write: w, writedata: {24'h000000, d}};
        do begin
            @(posedge clk);
        end while (rsp.waitrequest !== 1'b0);
        q = rsp.readdata[7:0];
        req.read <= 1'b0;
        req.write <= 1'b0;
    endtask
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        tally_and_finish();
    end
    initial begin
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            r = xs();
            if (i > 8 || i == 2 || i == 3) bus(1'b1, i[3:0], r[7:0]);
            bus(1'b0, i[3:0], 8'h00);
            if (i != 8) chk("reset or refused", 8'h00, q);
        end
        bus(1'b1, IDX_CTRL_A, 8'h07);
        bus(1'b0, IDX_CTRL_A, 8'h00);
        chk("ctrl a low bits", 8'h00, q);
        repeat (4) begin
            r = xs();
            for (int j = 0; j < 4; j++) bus(1'b1, IDX_CMPA_LO + j[3:0], r[8*j+:8]);
            for (int j = 0; j < 4; j++) begin
                bus(1'b0, IDX_CMPA_LO + j[3:0], 8'h00);
                chk("readback", j[0] ? {6'h00, r[8*j+:2]} : r[8*j+:8], q);
            end
        end
        bus(1'b1, IDX_PER_LO, 8'h00);
        bus(1'b1, IDX_PER_HI, 8'h00);
        bus(1'b1, IDX_CTRL_B, 8'hC0);
        for (int c = 0; c < 8; c++) begin
            bus(1'b1, IDX_CTRL_A, {1'b0, c[2:0], 4'h8});
            if (c >= 6) peer.pulses(5);
            else if (c >= 4) repeat (5) begin
                @(posedge clk);
                sub_clk_tick <= 1'b1;
                @(posedge clk);
                sub_clk_tick <= 1'b0;
            end
            else repeat (c[1] ? 640 : 40) @(posedge clk);
            bus(1'b1, IDX_CTRL_A, {1'b0, c[2:0], 4'h0});
            bus(1'b0, IDX_COUNT_LO, 8'h00);
            q2 = q;
            repeat (20) @(posedge clk);
            bus(1'b0, IDX_COUNT_LO, 8'h00);
            chk("residual", q2, q);
            chk("count", 8'h01, {7'h00, in_win(q, c > 3 ? 5 : c % 3 ? 40 : 10, c < 4)});
        end
        bus(1'b1, IDX_CTRL_A, 8'h18);
        repeat (600) @(posedge clk);
        bus(1'b1, IDX_CTRL_A, 8'h98);
        bus(1'b0, IDX_COUNT_HI, 8'h00);
        chk("paused high", 8'h02, q);
        bus(1'b0, IDX_COUNT_LO, 8'h00);
        q2 = q;
        repeat (20) @(posedge clk);
        bus(1'b0, IDX_COUNT_LO, 8'h00);
        chk("paused low", q2, q);
        bus(1'b1, IDX_CTRL_A, 8'h18);
        repeat (30) @(posedge clk);
        bus(1'b0, IDX_COUNT_LO, 8'h00);
        chk("resumed", 8'h01, {7'h00, in_win(q, int'(q2) + 33, 1'b1)});
        bus(1'b1, IDX_CTRL_A, 8'h10);
        bus(1'b1, IDX_CTRL_A, 8'h18);
        bus(1'b0, IDX_COUNT_HI, 8'h00);
        chk("restart", 8'h00, q);
        bus(1'b1, IDX_CTRL_A, 8'h10);
        bus(1'b1, IDX_CMPA_LO, 8'h14);
        bus(1'b1, IDX_CMPA_HI, 8'h00);
        for (int f = 0; f < 8; f++) begin
            r = xs();
            bus(1'b1, IDX_CTRL_B, {2'b00, f[1:0], r[0], f[2], 2'b01});
            bus(1'b1, IDX_CTRL_A, 8'h18);
            repeat (30) @(posedge clk);
            @(negedge clk);
            chk("match level", {7'h00, lvl(f[1:0], r[0]) ^ f[2]}, {7'h00, wave});
            bus(1'b1, IDX_CTRL_A, 8'h10);
            bus(1'b1, IDX_CTRL_A, 8'h18);
            repeat (3) @(posedge clk);
            @(negedge clk);
            chk("restart level", {7'h00, r[0] ^ f[2]}, {7'h00, wave});
            bus(1'b1, IDX_CTRL_A, 8'h10);
        end
        for (int f = 0; f < 4; f++) begin
            bus(1'b1, IDX_CTRL_B, {3'b100, f[0], f[1], 3'h0});
            bus(1'b1, IDX_CTRL_A, 8'h18);
            repeat (10) @(posedge clk);
            @(negedge clk);
            chk("forced level", {7'h00, f[0] ~^ f[1]}, {7'h00, wave});
            bus(1'b1, IDX_CTRL_A, 8'h10);
        end
        for (int f = 0; f < 4; f++) begin
            bus(1'b1, IDX_CMPA_LO, 8'hAA);
            bus(1'b1, IDX_CTRL_B, {2'b01, f[1:0], 4'h2});
            bus(1'b1, IDX_CTRL_A, 8'h18);
            repeat (40) @(posedge clk);
            irq_base = irq_seen;
            peer.pulses(1);
            bus(1'b1, IDX_CTRL_A, 8'h10);
            bus(1'b0, IDX_CMPA_LO, 8'h00);
            chk("capture", {7'h00, f == 3}, {7'h00, q == 8'hAA});
            chk("capture irqs", f == 2 ? 8'h02 : f == 3 ? 8'h00 : 8'h01, 8'(irq_seen - irq_base));
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
